// file: hdl/nv_access_regs.vh
/*
 Constants for the EEPROM access control block: data-space offsets,
 control bit positions, reset values and timing figures.
 Assumes inclusion by bare name from hdl/ files.
*/
`ifndef NV_ACCESS_REGS_VH
`define NV_ACCESS_REGS_VH

// ****************************************
// Data-space offsets
// ****************************************
`define OFS_CONTROL 12'h03f
`define OFS_DATA 12'h040
`define OFS_ADDR_LO 12'h041
`define OFS_ADDR_HI 12'h042
`define OFS_STORE0 12'h03e
`define OFS_STORE1 12'h04a
`define OFS_STORE2 12'h04b
`define IO_SHIFT 12'h020
`define IO_LIMIT 12'h03f
`define EXT_IO_BASE 12'h060

// ****************************************
// Control register fields
// ****************************************
`define BIT_READ 0
`define BIT_WRITE 1
`define BIT_ARM 2
`define BIT_IRQ_EN 3
`define BIT_MODE_LO 4
`define BIT_MODE_HI 5
`define MODE_ATOMIC 2'h0
`define MODE_ERASE 2'h1
`define MODE_WRITE 2'h2
`define MODE_RESERVED 2'h3

// ****************************************
// Reset values, timing and address limit
// ****************************************
`define STORE_RESET 8'h00
`define ARM_WINDOW 3'h4
`define WRITE_STALL 3'h2
`define READ_STALL 3'h4
`define RC_CYCLES_ATOMIC 26368
`define RC_CYCLES_SHORT 13960
`define ADDR_MAX 11'h7ff

`endif

// file: hdl/nv_write_timer.v
/*
 Write-time counter. Counts calibrated RC oscillator ticks while a
 programming action runs and reports completion.
 Assumes rc_tick is already synchronous to REF_CLK, one cycle wide.
*/
`timescale 1ns/1ps
`include "nv_access_regs.vh"

module nv_write_timer
#(
   parameter ATOMIC_TICKS = `RC_CYCLES_ATOMIC,
   parameter SHORT_TICKS = `RC_CYCLES_SHORT
)
(
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Control
   input wire start,
   input wire [1:0] mode,
   input wire rc_tick,
   // Status
   output reg done
);

   reg [15:0] count;
   reg running;
   wire [15:0] limit = (mode == `MODE_ATOMIC) ? ATOMIC_TICKS[15:0] : SHORT_TICKS[15:0];

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= 16'h0000;
         running <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            count <= 16'h0000;
            running <= 1'b1;
         end
         else if (running && rc_tick)
         begin
            if (count == limit - 16'h0001)
            begin
               running <= 1'b0;
               done <= 1'b1;
            end
            count <= count + 16'h0001;
         end
      end
   end

endmodule

// file: hdl/nv_access_control.v
/*
 EEPROM access control: control, data and address registers, armed
 write strobe, read strobe with CPU stall, flash interlock, ready
 interrupt request, and three general storage registers.
 Assumes a CPU register port on REF_CLK with one write and one read strobe
 shared by both spaces under IO_SPACE, and an EEPROM array with combinational read data.
*/
`timescale 1ns/1ps
`include "nv_access_regs.vh"

module nv_access_control
#(
   parameter ATOMIC_TICKS = `RC_CYCLES_ATOMIC,
   parameter SHORT_TICKS = `RC_CYCLES_SHORT
)
(
   // Clock and reset
   input wire REF_CLK,
   input wire RESET_N,
   // CPU register port
   input wire [11:0] ADDR,
   input wire IO_SPACE,
   input wire WR_EN,
   input wire RD_EN,
   input wire [7:0] WDATA,
   output reg [7:0] RDATA,
   output wire CPU_STALL,
   // System status
   input wire FLASH_SELFPROG_ENABLE,
   input wire RC_CLK,
   output wire NV_READY_IRQ,
   // EEPROM array
   output wire [10:0] NV_ARRAY_ADDR,
   output reg [7:0] NV_ARRAY_WDATA,
   input wire [7:0] NV_ARRAY_RDATA,
   output wire NV_ARRAY_PROGRAM,
   output wire [1:0] NV_ARRAY_MODE
);

   reg [7:0] general_storage_0;
   reg [7:0] general_storage_1;
   reg [7:0] general_storage_2;
   reg [7:0] nv_byte_data;
   reg [10:0] nv_byte_address;
   reg [1:0] nv_program_mode;
   reg nv_ready_irq_enable;
   reg nv_write_arm;
   reg nv_write_strobe;
   reg [2:0] arm_count;
   reg [2:0] stall_count;
   reg write_start;
   reg [2:0] rc_sync;
   reg rc_last;
   wire write_done;
   wire rc_tick;
   wire [11:0] eff_addr;
   wire access_ok;
   wire wr;
   wire ctl_wr;
   wire strobe_ok;

   // ****************************************
   // Address decode
   // ****************************************
   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   assign eff_addr = IO_SPACE ? ADDR + `IO_SHIFT : ADDR;
   // I/O opcodes reach only 0x00..0x3F; nothing beyond 0x60 that way
   assign access_ok = !IO_SPACE || (ADDR <= `IO_LIMIT);
   assign wr = WR_EN && access_ok;
   assign ctl_wr = wr && hit(eff_addr, `OFS_CONTROL);
   assign strobe_ok = nv_write_arm && !nv_write_strobe && !FLASH_SELFPROG_ENABLE;

   // ****************************************
   // RC oscillator tick
   // ****************************************
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rc_sync <= 3'h0;
         rc_last <= 1'b0;
      end
      else
      begin
         rc_sync <= {rc_sync[1:0], RC_CLK};
         if (rc_sync[2] == rc_sync[1])
            rc_last <= rc_sync[2];
      end
   end
   assign rc_tick = (rc_sync[2] == rc_sync[1]) && rc_sync[2] && !rc_last;

   nv_write_timer
   #(
      .ATOMIC_TICKS(ATOMIC_TICKS),
      .SHORT_TICKS(SHORT_TICKS)
   )
   u_timer
   (
      .clk(REF_CLK),
      .reset_n(RESET_N),
      .start(write_start),
      .mode(nv_program_mode),
      .rc_tick(rc_tick),
      .done(write_done)
   );

   // ****************************************
   // Register writes and control sequencing
   // ****************************************
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         general_storage_0 <= `STORE_RESET;
         general_storage_1 <= `STORE_RESET;
         general_storage_2 <= `STORE_RESET;
         nv_byte_data <= 8'h00;
         nv_byte_address <= 11'h000;
         nv_program_mode <= `MODE_ATOMIC;
         nv_ready_irq_enable <= 1'b0;
         nv_write_arm <= 1'b0;
         nv_write_strobe <= 1'b0;
         arm_count <= 3'h0;
         stall_count <= 3'h0;
         write_start <= 1'b0;
         NV_ARRAY_WDATA <= 8'h00;
      end
      else
      begin
         write_start <= 1'b0;
         if (stall_count != 3'h0)
            stall_count <= stall_count - 3'h1;
         if (nv_write_arm)
         begin
            if (arm_count == `ARM_WINDOW - 3'h1)
               nv_write_arm <= 1'b0;
            arm_count <= arm_count + 3'h1;
         end
         if (write_done)
            nv_write_strobe <= 1'b0;
         if (wr && hit(eff_addr, `OFS_STORE0))
            general_storage_0 <= WDATA;
         if (wr && hit(eff_addr, `OFS_STORE1))
            general_storage_1 <= WDATA;
         if (wr && hit(eff_addr, `OFS_STORE2))
            general_storage_2 <= WDATA;
         if (wr && hit(eff_addr, `OFS_DATA))
            nv_byte_data <= WDATA;
         // Address frozen while a write runs
         if (wr && !nv_write_strobe && hit(eff_addr, `OFS_ADDR_LO))
            nv_byte_address[7:0] <= WDATA;
         if (wr && !nv_write_strobe && hit(eff_addr, `OFS_ADDR_HI))
            nv_byte_address[10:8] <= WDATA[2:0];
         if (ctl_wr)
         begin
            nv_ready_irq_enable <= WDATA[`BIT_IRQ_EN];
            if (!nv_write_strobe)
               nv_program_mode <= WDATA[`BIT_MODE_HI:`BIT_MODE_LO];
            if (WDATA[`BIT_ARM] && !WDATA[`BIT_WRITE])
            begin
               nv_write_arm <= 1'b1;
               arm_count <= 3'h0;
            end
            // Reserved mode is not started; the strobe is simply dropped
            if (WDATA[`BIT_WRITE] && strobe_ok
                && nv_program_mode != `MODE_RESERVED)
            begin
               nv_write_strobe <= 1'b1;
               nv_write_arm <= 1'b0;
               write_start <= 1'b1;
               NV_ARRAY_WDATA <= nv_byte_data;
               stall_count <= `WRITE_STALL;
            end
            else if (WDATA[`BIT_READ] && !nv_write_strobe)
            begin
               nv_byte_data <= NV_ARRAY_RDATA;
               stall_count <= `READ_STALL;
            end
         end
      end
   end

   // ****************************************
   // Read mux and outputs
   // ****************************************
   always @(posedge REF_CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         RDATA <= 8'h00;
      else if (RD_EN && access_ok)
      begin
         if (hit(eff_addr, `OFS_CONTROL))
            RDATA <= {2'h0, nv_program_mode, nv_ready_irq_enable,
                      nv_write_arm, nv_write_strobe, 1'b0};
         else if (hit(eff_addr, `OFS_DATA))
            RDATA <= nv_byte_data;
         else if (hit(eff_addr, `OFS_ADDR_LO))
            RDATA <= nv_byte_address[7:0];
         else if (hit(eff_addr, `OFS_ADDR_HI))
            RDATA <= {5'h00, nv_byte_address[10:8]};
         else if (hit(eff_addr, `OFS_STORE0))
            RDATA <= general_storage_0;
         else if (hit(eff_addr, `OFS_STORE1))
            RDATA <= general_storage_1;
         else if (hit(eff_addr, `OFS_STORE2))
            RDATA <= general_storage_2;
         else
            RDATA <= 8'h00;
      end
      else
         RDATA <= 8'h00;
   end

   assign CPU_STALL = (stall_count != 3'h0);
   assign NV_READY_IRQ = nv_ready_irq_enable && !nv_write_strobe
                         && !FLASH_SELFPROG_ENABLE;
   assign NV_ARRAY_ADDR = nv_byte_address;
   assign NV_ARRAY_PROGRAM = nv_write_strobe;
   assign NV_ARRAY_MODE = nv_program_mode;

endmodule

// file: testbench/nv_access_asserts.sv
/*
 Port-level checker for the EEPROM access block.
 Assumes a single REF_CLK domain with RESET_N asynchronous, active low.
*/
`timescale 1ns/1ps

module nv_access_asserts
(
   // Clock and reset
   input wire REF_CLK,
   input wire RESET_N,
   // CPU register port
   input wire [11:0] ADDR,
   input wire IO_SPACE,
   input wire WR_EN,
   input wire [7:0] WDATA,
   input wire CPU_STALL,
   // Status and array
   input wire FLASH_SELFPROG_ENABLE,
   input wire NV_READY_IRQ,
   input wire [10:0] NV_ARRAY_ADDR,
   input wire NV_ARRAY_PROGRAM,
   input wire [1:0] NV_ARRAY_MODE
);
   wire ctl_wr = WR_EN && (IO_SPACE ? ADDR == 12'h01f : ADDR == 12'h03f);
   wire lo_wr = WR_EN && (IO_SPACE ? ADDR == 12'h021 : ADDR == 12'h041);
   // Arming write: arm bit set with the strobe bit clear in the same write
   wire arm_wr = ctl_wr && WDATA[2] && !WDATA[1];

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   a_write_stall:
      assert property ($rose(NV_ARRAY_PROGRAM) |-> CPU_STALL ##1 CPU_STALL ##1 !CPU_STALL)
      else $error("write stall length wrong");
   a_read_stall:
      assert property (ctl_wr && WDATA[0] && !NV_ARRAY_PROGRAM && !CPU_STALL
         |=> CPU_STALL[*4] ##1 !CPU_STALL) else $error("read stall length wrong");
   a_strobe_cause:
      assert property ($rose(NV_ARRAY_PROGRAM) |-> $past(ctl_wr) && $past(WDATA[1]))
      else $error("write started without strobe");
   a_arm_window:
      assert property ($rose(NV_ARRAY_PROGRAM) |-> $past(arm_wr, 2) || $past(arm_wr, 3)
         || $past(arm_wr, 4) || $past(arm_wr, 5))
      else $error("write started outside arming window");
   a_read_refused:
      assert property (ctl_wr && WDATA[0] && NV_ARRAY_PROGRAM && !CPU_STALL |=> !CPU_STALL)
      else $error("read accepted during write");
   a_no_selfprog:
      assert property ($rose(NV_ARRAY_PROGRAM) |-> !$past(FLASH_SELFPROG_ENABLE))
      else $error("write started during flash programming");
   a_addr_frozen:
      assert property (NV_ARRAY_PROGRAM && lo_wr |=> $stable(NV_ARRAY_ADDR))
      else $error("address changed during write");
   a_mode_frozen:
      assert property (NV_ARRAY_PROGRAM && $past(NV_ARRAY_PROGRAM) |-> $stable(NV_ARRAY_MODE))
      else $error("mode changed during write");
   a_irq_level:
      assert property (NV_READY_IRQ |-> !NV_ARRAY_PROGRAM && !FLASH_SELFPROG_ENABLE)
      else $error("ready request while busy");
   a_write_min:
      assert property ($rose(NV_ARRAY_PROGRAM) |-> NV_ARRAY_PROGRAM[*8])
      else $error("write ended too soon");
   a_write_ends:
      assert property (NV_ARRAY_PROGRAM |-> ##[1:300] !NV_ARRAY_PROGRAM)
      else $error("strobe never cleared");

   c_write: cover property ($rose(NV_ARRAY_PROGRAM));
   c_done: cover property ($fell(NV_ARRAY_PROGRAM));
   c_read: cover property (ctl_wr && WDATA[0]);
endmodule

bind nv_access_control nv_access_asserts i_chk
(
   .REF_CLK(REF_CLK),
   .RESET_N(RESET_N),
   .ADDR(ADDR),
   .IO_SPACE(IO_SPACE),
   .WR_EN(WR_EN),
   .WDATA(WDATA),
   .CPU_STALL(CPU_STALL),
   .FLASH_SELFPROG_ENABLE(FLASH_SELFPROG_ENABLE),
   .NV_READY_IRQ(NV_READY_IRQ),
   .NV_ARRAY_ADDR(NV_ARRAY_ADDR),
   .NV_ARRAY_PROGRAM(NV_ARRAY_PROGRAM),
   .NV_ARRAY_MODE(NV_ARRAY_MODE)
);

// file: testbench/tb_nv_access_control.sv
/*
 Self-checking bench for the EEPROM access block.
 Assumes the design header on the include path; RC clock made here.
*/
`timescale 1ns/1ps
`include "nv_access_regs.vh"

module tb_nv_access_control;
   reg REF_CLK = 0, RESET_N = 0, IO_SPACE = 0, WR_EN = 0, RD_EN = 0;
   reg FLASH_SELFPROG_ENABLE = 0, RC_CLK = 0;
   reg [11:0] ADDR = 0;
   reg [7:0] WDATA = 0, NV_ARRAY_RDATA = 0, rv;
   wire [7:0] RDATA, NV_ARRAY_WDATA;
   wire [10:0] NV_ARRAY_ADDR;
   wire [1:0] NV_ARRAY_MODE;
   wire CPU_STALL, NV_READY_IRQ, NV_ARRAY_PROGRAM;
   integer num_errors = 0, compares = 0, cyc = 0, n, i;

   nv_access_control #(.ATOMIC_TICKS(8), .SHORT_TICKS(4)) i_dut (
      .REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .IO_SPACE(IO_SPACE),
      .WR_EN(WR_EN), .RD_EN(RD_EN), .WDATA(WDATA), .RDATA(RDATA), .CPU_STALL(CPU_STALL),
      .FLASH_SELFPROG_ENABLE(FLASH_SELFPROG_ENABLE), .RC_CLK(RC_CLK),
      .NV_READY_IRQ(NV_READY_IRQ), .NV_ARRAY_ADDR(NV_ARRAY_ADDR),
      .NV_ARRAY_WDATA(NV_ARRAY_WDATA), .NV_ARRAY_RDATA(NV_ARRAY_RDATA),
      .NV_ARRAY_PROGRAM(NV_ARRAY_PROGRAM), .NV_ARRAY_MODE(NV_ARRAY_MODE));

   // RC oscillator: eight REF_CLK cycles per tick
   always #5 REF_CLK = ~REF_CLK;
   always #40 RC_CLK = ~RC_CLK;

   task complete_run;
      begin
         if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask

   always @(posedge REF_CLK)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         complete_run;
      end
   end

   task chk(input [15:0] got, input [15:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [11:0] a, input [7:0] d, input io);
      begin
         @(negedge REF_CLK);
         ADDR = a;
         WDATA = d;
         IO_SPACE = io;
         WR_EN = 1;
         @(negedge REF_CLK);
         WR_EN = 0;
      end
   endtask

   task rd(input [11:0] a, input io);
      begin
         @(negedge REF_CLK);
         ADDR = a;
         IO_SPACE = io;
         RD_EN = 1;
         @(negedge REF_CLK);
         RD_EN = 0;
         rv = RDATA;
      end
   endtask

   task stall;
      begin
         n = 0;
         while (CPU_STALL === 1'b1 && n < 9)
         begin
            n = n + 1;
            @(negedge REF_CLK);
         end
      end
   endtask

   task t_store;
      reg [11:0] a;
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            a = (i == 0) ? `OFS_STORE0 : (i == 1) ? `OFS_STORE1 : `OFS_STORE2;
            rd(a, 0);
            chk(rv, `STORE_RESET);
            wr(a - `IO_SHIFT, 8'ha0 + i, 1);
            rd(a, 0);
            chk(rv, 8'ha0 + i);
         end
         wr(`OFS_STORE2, 8'h5c, 1);
         rd(`OFS_STORE2 - `IO_SHIFT, 1);
         chk(rv, 8'ha2);
         rd(`OFS_STORE1, 1);
         chk(rv, 8'h00);
         rd(`EXT_IO_BASE, 0);
         chk(rv, 8'h00);
      end
   endtask

   task t_refuse;
      begin
         wr(`OFS_CONTROL, 8'h02, 0);
         chk(NV_ARRAY_PROGRAM, 0);
         wr(`OFS_CONTROL, 8'h04, 0);
         // Strobe lands one edge after the arm bit expires
         repeat (3) @(negedge REF_CLK);
         wr(`OFS_CONTROL, 8'h02, 0);
         chk(NV_ARRAY_PROGRAM, 0);
         wr(`OFS_CONTROL, 8'h06, 0);
         chk(NV_ARRAY_PROGRAM, 0);
         FLASH_SELFPROG_ENABLE = 1;
         wr(`OFS_CONTROL, 8'h0c, 0);
         wr(`OFS_CONTROL, 8'h0a, 0);
         chk({NV_ARRAY_PROGRAM, NV_READY_IRQ}, 0);
         FLASH_SELFPROG_ENABLE = 0;
         wr(`OFS_CONTROL, 8'h34, 0);
         wr(`OFS_CONTROL, 8'h32, 0);
         chk(NV_ARRAY_PROGRAM, 0);
      end
   endtask

   task t_write(input [1:0] mode, input integer ticks, input integer gap);
      reg [7:0] c;
      begin
         c = {2'b00, mode, 4'h8};
         wr(`OFS_ADDR_LO, 8'hff, 0);
         wr(`OFS_ADDR_HI, 8'h07, 0);
         wr(`OFS_DATA, 8'h5a, 0);
         wr(`OFS_CONTROL, c | 8'h04, 0);
         // Gap 2 puts the strobe on the last edge of the arming window
         repeat (gap) @(negedge REF_CLK);
         wr(`OFS_CONTROL, c | 8'h02, 0);
         stall;
         chk(n, 2);
         chk({NV_ARRAY_PROGRAM, NV_ARRAY_MODE, NV_ARRAY_ADDR}, {1'b1, mode, 11'h7ff});
         chk({NV_ARRAY_WDATA, NV_READY_IRQ}, {8'h5a, 1'b0});
         NV_ARRAY_RDATA = 8'h3c;
         // Read and a different mode tried while busy: both must be ignored
         wr(`OFS_CONTROL, (c ^ 8'h30) | 8'h01, 0);
         wr(`OFS_ADDR_LO, 8'h00, 0);
         chk({NV_ARRAY_MODE, NV_ARRAY_ADDR}, {mode, 11'h7ff});
         rd(`OFS_DATA, 0);
         chk(rv, 8'h5a);
         rd(`OFS_CONTROL, 0);
         chk(rv[1], 1);
         n = 0;
         while (NV_ARRAY_PROGRAM === 1'b1 && n < 2000)
         begin
            n = n + 1;
            @(negedge REF_CLK);
         end
         chk((n + 28 >= ticks * 8) && (n <= ticks * 8), 1);
         chk(NV_READY_IRQ, 1);
      end
   endtask

   task t_read;
      begin
         rd(`OFS_CONTROL, 0);
         chk(rv[1], 0);
         NV_ARRAY_RDATA = 8'hc3;
         wr(`OFS_ADDR_LO, 8'h23, 0);
         wr(`OFS_ADDR_HI, 8'h01, 0);
         wr(`OFS_CONTROL, 8'h01, 0);
         stall;
         chk(n, 4);
         chk(NV_ARRAY_ADDR, 11'h123);
         rd(`OFS_DATA, 0);
         chk(rv, 8'hc3);
         rd(`OFS_CONTROL, 0);
         chk(rv, 8'h00);
      end
   endtask

   initial
   begin
      repeat (6) @(negedge REF_CLK);
      RESET_N = 1;
      t_store;
      t_refuse;
      t_write(2'h0, 8, 0);
      t_write(2'h1, 4, 2);
      t_write(2'h2, 4, 1);
      t_read;
      complete_run;
   end
endmodule
